// ===== pkg/ext_bus_pkg.sv
// Constants and types for the external bus ready and arbitration block
package ext_bus_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_RDATA  = 8'h10;
	// Control field positions
	localparam int CTRL_POL   = 0;
	localparam int CTRL_ASYNC = 1;
	localparam int CTRL_RDYEN = 2;
	localparam int CTRL_ARBEN = 3;
	localparam int CTRL_LEN   = 8;
	// Command field positions
	localparam int CMD_GO    = 0;
	localparam int CMD_WRITE = 1;
	localparam int CMD_ADDR  = 16;
	// Status field positions
	localparam int STA_BUSY = 0;
	localparam int STA_REL  = 1;
	localparam int STA_WAIT = 8;
	// Reset value and response codes
	localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Synchroniser depth for a pin
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic       ready_pol;  // Level that means ready
		logic       async_mode; // Extra sync stage
		logic       ready_en;   // Ready decides cycle end
		logic [4:0] access_len; // Access phase length minus one
	} bus_cfg_t;

	typedef struct packed {
		logic        write;
		logic [15:0] addr;
		logic [15:0] wdata;
		bus_cfg_t    cfg;
	} bus_cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ACCESS    = 4'h2,
		ST_SYNC_WAIT = 4'h3,
		ST_READY     = 4'h4,
		ST_END       = 4'h5,
		ST_REL_DRIVE = 4'h6,
		ST_RELEASED  = 4'h7,
		ST_REGAIN    = 4'h8
	} bus_state_t;
endpackage : ext_bus_pkg

// ===== core/ext_bus_ctrl.sv
// External bus cycle, ready handshake and bus arbitration control
`timescale 1ns/1ns
// Summary of operation
// - Ready input polarity selectable by software
// - Asynchronous ready passes extra sync stage
// - Inactive ready inserts wait state, resamples
// - Active ready ends running bus cycle
// - Async sample point later than sync
// - Ready ignored during programmed access phase
// - Release bus on request when arbitration enabled
// - Finish running cycle before granting bus
// - Drive strobes inactive, then float, ale low
// - Regain starts when request withdrawn or arbitration disabled
// - Request withdrawal accepted without own request
// - Regain drives strobes inactive, ale low
// - Next cycle only after grant removed
module ext_bus_ctrl
	import ext_bus_pkg::*;
#(
	parameter int ADDR_W = 16, // Bus address width
	parameter int DATA_W = 16  // Bus data width
) (
	input  wire logic              aclk,          // Register clock
	input  wire logic              aresetn,       // Sync reset, low
	input  wire logic [7:0]        s_awaddr,      // Write address
	input  wire logic              s_awvalid,     // Write addr valid
	output logic                   s_awready,     // Write addr ready
	input  wire logic [31:0]       s_wdata,       // Write data
	input  wire logic [3:0]        s_wstrb,       // Byte enables
	input  wire logic              s_wvalid,      // Write data valid
	output logic                   s_wready,      // Write data ready
	output logic [1:0]             s_bresp,       // Write response
	output logic                   s_bvalid,      // Response valid
	input  wire logic              s_bready,      // Response ready
	input  wire logic [7:0]        s_araddr,      // Read address
	input  wire logic              s_arvalid,     // Read addr valid
	output logic                   s_arready,     // Read addr ready
	output logic [31:0]            s_rdata,       // Read data
	output logic [1:0]             s_rresp,       // Read response
	output logic                   s_rvalid,      // Read data valid
	input  wire logic              s_rready,      // Read data ready
	input  wire logic              bus_clk,       // Bus side clock
	input  wire logic              ready_in,      // Wait handshake pin
	input  wire logic              hold_req_n,    // Release request
	output logic                   bus_release_grant_n,  // Grant
	output logic                   bus_regain_request_n, // Want bus
	output logic [ADDR_W-1:0]      bus_addr,      // Address pins
	output logic                   ale_o,         // Addr latch enable
	output logic                   ale_oe_n,      // Ale enable, low
	output logic                   rd_n_o,        // Read strobe
	output logic                   wr_n_o,        // Write strobe
	output logic                   strobe_oe_n,   // Strobe enable
	output logic [DATA_W-1:0]      data_o,        // Data out
	output logic                   data_oe_n,     // Data enable
	input  wire logic [DATA_W-1:0] data_i         // Data in
);
	// Elaboration check: command and data paths are 16 bits wide
	if (ADDR_W != 16 || DATA_W != 16)
	begin : g_width_check
		$error("ext_bus_ctrl serves 16 bit address and data");
	end

	// Merge a write word into a register by byte lanes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	// Offset decode shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		return a == OFS_CTRL || a == OFS_CMD || a == OFS_WDATA ||
			a == OFS_STATUS || a == OFS_RDATA;
	endfunction : mapped

	// Register side state
	logic [31:0] ctrl;
	logic [31:0] cmd_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic [7:0]  wait_reg;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        req_tgl;
	logic        ack_s1;
	logic        ack_s2;
	logic        ack_prev;
	logic        rel_s1;
	logic        rel_s2;
	logic        busy;
	logic        do_write;
	logic        go;

	// Bus side state
	logic        brst_s1;
	logic        brst_n;
	logic        req_s1;
	logic        req_s2;
	logic        req_seen;
	logic        ack_tgl;
	logic        arb_s1;
	logic        arb_s2;
	logic [SYNC_STAGES-1:0] hold_sync;
	logic [SYNC_STAGES:0]   rdy_sync;
	logic [DATA_W-1:0]      din_a;
	logic [DATA_W-1:0]      din_b;
	bus_state_t  state;
	bus_state_t  next_state;
	bus_cmd_t    cur;
	logic [4:0]  phase_cnt;
	logic [7:0]  wait_cnt;
	logic [DATA_W-1:0] rd_latch;
	logic        pending;
	logic        hold_act;
	logic        rdy_sel;
	logic        rdy_act;

	// Write and read channel handshakes, each channel taken alone
	assign s_awready = !aw_held;
	assign s_wready  = !w_held;
	assign s_arready = !s_rvalid;
	assign do_write  = aw_held && w_held && !s_bvalid;
	// Busy holds until result registers have been loaded
	assign busy      = req_tgl != ack_prev;
	assign go        = do_write && aw_addr == OFS_CMD &&
		w_strb[0] && w_data[CMD_GO];

	// Hold write address and data until both present
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_awaddr;
			end
			else if (do_write)
				aw_held <= 1'b0;
			if (s_wvalid && s_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_wdata;
				w_strb <= s_wstrb;
			end
			else if (do_write)
				w_held <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_bvalid <= 1'b0;
			s_bresp  <= RESP_OKAY;
		end
		else if (do_write)
		begin
			s_bvalid <= 1'b1;
			s_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_bready)
			s_bvalid <= 1'b0;
	end

	// Software registers; command fields frozen while busy
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl      <= CTRL_RESET;
			cmd_reg   <= 32'h0000_0000;
			wdata_reg <= 32'h0000_0000;
			req_tgl   <= 1'b0;
		end
		else if (do_write && !busy)
		begin
			if (aw_addr == OFS_CTRL)
				ctrl <= merge(ctrl, w_data, w_strb);
			if (aw_addr == OFS_WDATA)
				wdata_reg <= merge(wdata_reg, w_data, w_strb);
			if (aw_addr == OFS_CMD)
				cmd_reg <= merge(cmd_reg, w_data, w_strb) &
					32'hffff_fffe;
			if (go)
				req_tgl <= !req_tgl;
		end
		else if (do_write && aw_addr == OFS_CTRL)
			ctrl[CTRL_ARBEN] <= w_strb[0] ? w_data[CTRL_ARBEN] :
				ctrl[CTRL_ARBEN];
	end

	// Completion and release flags cross in from the bus side
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ack_s1   <= 1'b0;
			ack_s2   <= 1'b0;
			ack_prev <= 1'b0;
			rel_s1   <= 1'b0;
			rel_s2   <= 1'b0;
		end
		else
		begin
			ack_s1   <= ack_tgl;
			ack_s2   <= ack_s1;
			ack_prev <= ack_s2;
			rel_s1   <= !bus_release_grant_n;
			rel_s2   <= rel_s1;
		end
	end

	// Results are stable on the bus side once the ack toggles
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rdata_reg <= 32'h0000_0000;
			wait_reg  <= 8'h00;
		end
		else if (ack_s2 != ack_prev)
		begin
			rdata_reg <= {16'h0000, rd_latch};
			wait_reg  <= wait_cnt;
		end
	end

	// Read channel, unmapped offsets answer with an error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= RESP_OKAY;
		end
		else if (s_arvalid && s_arready)
		begin
			s_rvalid <= 1'b1;
			s_rresp  <= mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_araddr)
				OFS_CTRL:   s_rdata <= ctrl;
				OFS_CMD:    s_rdata <= cmd_reg;
				OFS_WDATA:  s_rdata <= wdata_reg;
				OFS_STATUS: s_rdata <= {16'h0000, wait_reg,
					6'h00, rel_s2, busy};
				OFS_RDATA:  s_rdata <= rdata_reg;
				default:    s_rdata <= 32'h0000_0000;
			endcase
		end
		else if (s_rready)
			s_rvalid <= 1'b0;
	end

	// Bus side reset and control level synchronisers
	always_ff @(posedge bus_clk)
	begin
		brst_s1 <= aresetn;
		brst_n  <= brst_s1;
		req_s1  <= req_tgl;
		req_s2  <= req_s1;
		arb_s1  <= ctrl[CTRL_ARBEN];
		arb_s2  <= arb_s1;
	end

	// Pin synchronisers; async ready gets one more stage
	always_ff @(posedge bus_clk)
	begin
		hold_sync <= {hold_sync[0], hold_req_n};
		rdy_sync  <= {rdy_sync[SYNC_STAGES-1:0], ready_in};
		din_a     <= data_i;
		din_b     <= din_a;
	end

	assign pending  = req_s2 != req_seen;
	assign hold_act = arb_s2 && !hold_sync[1];
	// Later sample point in async mode via third stage
	assign rdy_sel  = cur.cfg.async_mode ? rdy_sync[2] :
		rdy_sync[1];
	assign rdy_act  = rdy_sel == cur.cfg.ready_pol;

	// Next state of the bus cycle and arbitration sequence
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (hold_act)
					next_state = ST_REL_DRIVE;
				else if (pending)
					next_state = ST_ADDR;
			ST_ADDR:
				next_state = ST_ACCESS;
			ST_ACCESS:
				if (phase_cnt == 5'h00)
				begin
					if (!cur.cfg.ready_en)
						next_state = ST_END;
					else if (cur.cfg.async_mode)
						next_state = ST_SYNC_WAIT;
					else
						next_state = ST_READY;
				end
			ST_SYNC_WAIT:
				next_state = ST_READY;
			ST_READY:
				if (rdy_act)
					next_state = ST_END;
			ST_END:
				next_state = ST_IDLE;
			ST_REL_DRIVE:
				next_state = ST_RELEASED;
			ST_RELEASED:
				if (hold_sync[1] || !arb_s2)
					next_state = ST_REGAIN;
			ST_REGAIN:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	// State register and command capture
	always_ff @(posedge bus_clk)
	begin
		if (!brst_n)
		begin
			state    <= ST_IDLE;
			cur      <= '0;
			req_seen <= 1'b0;
			ack_tgl  <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (state == ST_IDLE && next_state == ST_ADDR)
			begin
				// Command words are held still while pending
				cur.write <= cmd_reg[CMD_WRITE];
				cur.addr  <= cmd_reg[CMD_ADDR +: 16];
				cur.wdata <= wdata_reg[15:0];
				cur.cfg   <= '{ready_pol: ctrl[CTRL_POL],
					async_mode: ctrl[CTRL_ASYNC],
					ready_en: ctrl[CTRL_RDYEN],
					access_len: ctrl[CTRL_LEN +: 5]};
			end
			if (state == ST_END)
			begin
				req_seen <= req_s2;
				ack_tgl  <= req_s2;
			end
		end
	end

	// Access phase countdown and ready wait state count
	always_ff @(posedge bus_clk)
	begin
		if (!brst_n)
		begin
			phase_cnt <= 5'h00;
			wait_cnt  <= 8'h00;
			rd_latch  <= '0;
		end
		else
		begin
			if (state == ST_ADDR)
			begin
				phase_cnt <= cur.cfg.access_len;
				wait_cnt  <= 8'h00;
			end
			else if (state == ST_ACCESS && phase_cnt != 5'h00)
				phase_cnt <= phase_cnt - 5'h01;
			if ((state == ST_READY && !rdy_act) ||
				state == ST_SYNC_WAIT)
				wait_cnt <= wait_cnt + 8'h01;
			if (next_state == ST_END && state != ST_END &&
				!cur.write)
				rd_latch <= din_b;
		end
	end

	// Pin drivers, registered from the next state
	always_ff @(posedge bus_clk)
	begin
		if (!brst_n)
		begin
			ale_o       <= 1'b0;
			ale_oe_n    <= 1'b0;
			rd_n_o      <= 1'b1;
			wr_n_o      <= 1'b1;
			strobe_oe_n <= 1'b0;
			data_oe_n   <= 1'b1;
			data_o      <= '0;
			bus_addr    <= '0;
		end
		else
		begin
			ale_o <= next_state == ST_ADDR;
			// Ale stays driven low while the bus is away
			ale_oe_n <= 1'b0;
			rd_n_o <= !(!cur.write && (next_state == ST_ACCESS ||
				next_state == ST_SYNC_WAIT ||
				next_state == ST_READY));
			wr_n_o <= !(cur.write && (next_state == ST_ACCESS ||
				next_state == ST_SYNC_WAIT ||
				next_state == ST_READY));
			strobe_oe_n <= next_state == ST_RELEASED;
			data_oe_n <= !(cur.write && next_state != ST_IDLE &&
				next_state != ST_RELEASED &&
				next_state != ST_REL_DRIVE &&
				next_state != ST_REGAIN);
			data_o   <= cur.wdata;
			bus_addr <= cur.addr;
		end
	end

	// Arbitration outputs on clock edges only
	always_ff @(posedge bus_clk)
	begin
		if (!brst_n)
		begin
			bus_release_grant_n  <= 1'b1;
			bus_regain_request_n <= 1'b1;
		end
		else
		begin
			// Grant drops only after regain drive, then idle
			bus_release_grant_n <= !(next_state == ST_RELEASED ||
				next_state == ST_REGAIN);
			bus_regain_request_n <= !(next_state == ST_RELEASED &&
				pending);
		end
	end
endmodule : ext_bus_ctrl

// ===== verif/ext_bus_chk.sv
// Checker for the bus release handshake at the pins
`timescale 1ns/1ns
module ext_bus_chk (
	input wire logic aresetn,              // Sync reset, low
	input wire logic bus_clk,              // Bus side clock
	input wire logic hold_req_n,           // Release request
	input wire logic bus_release_grant_n,  // Grant
	input wire logic bus_regain_request_n, // Want bus back
	input wire logic ale_o,                // Addr latch enable
	input wire logic rd_n_o,               // Read strobe
	input wire logic wr_n_o,               // Write strobe
	input wire logic strobe_oe_n,          // Strobe enable
	input wire logic ale_oe_n              // Ale enable, low
);
	// All pins here but aresetn live in the bus clock domain
	default clocking @(posedge bus_clk);
	endclocking
	default disable iff (!aresetn);
	grant_drive_a: assert property ($fell(bus_release_grant_n) |->
		strobe_oe_n && !$past(strobe_oe_n) && $past(rd_n_o) && $past(wr_n_o))
		else $error("grant without strobes driven high first");
	grant_hold_a: assert property ($fell(bus_release_grant_n) |->
		!$past(hold_req_n, 2))
		else $error("grant without release request");
	float_grant_a: assert property (strobe_oe_n |->
		!bus_release_grant_n)
		else $error("strobes floated while bus not granted");
	grant_quiet_a: assert property (!bus_release_grant_n |->
		!ale_o && (strobe_oe_n || (rd_n_o && wr_n_o)))
		else $error("bus cycle activity while granted");
	regain_hold_a: assert property ($rose(bus_release_grant_n) |->
		$past(hold_req_n, 2))
		else $error("regain while release request held");
	regain_drive_a: assert property ($rose(bus_release_grant_n) |->
		!$past(strobe_oe_n) && $past(rd_n_o) && $past(wr_n_o))
		else $error("regain without strobes driven high");
	request_grant_a: assert property (!bus_regain_request_n |->
		!bus_release_grant_n)
		else $error("bus request while not released");
	cycle_resume_a: assert property ($rose(bus_release_grant_n) |->
		!ale_o && rd_n_o && wr_n_o && !strobe_oe_n)
		else $error("cycle started before grant removed");
	ale_driven_a: assert property (!ale_oe_n)
		else $error("address latch enable not driven");
	cover property ($fell(bus_release_grant_n));
	cover property (!bus_regain_request_n);
	cover property ($rose(bus_release_grant_n));
endmodule : ext_bus_chk

bind ext_bus_ctrl ext_bus_chk i_ext_bus_chk (
	.aresetn, .bus_clk, .hold_req_n, .bus_release_grant_n,
	.bus_regain_request_n, .ale_o, .rd_n_o, .wr_n_o, .strobe_oe_n, .ale_oe_n
);

// ===== verif/ext_bus_far.sv
// Far side model: ready-driving peripheral and second bus master
`timescale 1ns/1ns
module ext_bus_far (
	input  wire logic        bus_clk,     // Bus side clock
	input  wire logic        rd_n_o,      // Read strobe
	input  wire logic        wr_n_o,      // Write strobe
	input  wire logic        strobe_oe_n, // Strobe enable
	input  wire logic [15:0] bus_addr,    // Address pins
	input  wire logic [15:0] data_o,      // Write data pins
	input  wire logic        data_oe_n,   // Data enable, low
	input  wire logic        pol,         // Ready level
	input  wire logic [3:0]  dly,         // Clocks to ready
	input  wire logic        want_bus,    // Master wants bus
	output logic             ready_in,    // Ready pin
	output logic             hold_req_n = 1'b1, // Release request
	output logic [15:0]      data_i = 16'h0,    // Read data pins
	output logic [15:0]      wr_seen = 16'h0,   // Last write data
	output logic [7:0]       strobe_len = 8'h0  // Last strobe clocks
);
	logic       rd_w;
	logic       wr_w;
	logic [7:0] cnt = 8'h0;
	logic       rdy = 1'b0;
	// Pulled-up strobes read high while floating
	assign rd_w = strobe_oe_n | rd_n_o;
	assign wr_w = strobe_oe_n | wr_n_o;
	assign ready_in = rdy ~^ pol;
	// Ready after dly clocks, dropped once the strobe rises
	always @(posedge bus_clk)
	begin
		cnt <= (rd_w && wr_w) ? 8'h0 : cnt + 8'h01;
		rdy <= !(rd_w && wr_w) && cnt >= {4'h0, dly};
		if (!(rd_w && wr_w))
			strobe_len <= cnt + 8'h01;
		// Write data only counts while the device drives the pins
		if (!wr_w && !data_oe_n)
			wr_seen <= data_o;
		hold_req_n <= !want_bus;
		data_i <= rd_w ? ~data_i : ~bus_addr;
	end
endmodule : ext_bus_far

// ===== verif/tb_ext_bus_ready_and_arbitration.sv
// Self-checking bench for the ready handshake and bus release logic
`timescale 1ns/1ns
module tb_ext_bus_ready_and_arbitration import ext_bus_pkg::*;;
	logic        aclk = 1'b0;
	logic        bus_clk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_awaddr = 8'h00;
	logic        s_awvalid = 1'b0;
	logic [31:0] s_wdata = 32'h0;
	logic        s_wvalid = 1'b0;
	logic        s_bready = 1'b0;
	logic [7:0]  s_araddr = 8'h00;
	logic        s_arvalid = 1'b0;
	logic        s_rready = 1'b0;
	logic        pol = 1'b1;
	logic [3:0]  dly = 4'h0;
	logic        want_bus = 1'b0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]  s_bresp, s_rresp;
	logic [31:0] s_rdata;
	logic        ready_in, hold_req_n, ale_o, rd_n_o, wr_n_o, strobe_oe_n;
	logic        bus_release_grant_n, bus_regain_request_n;
	logic        data_oe_n;
	logic [15:0] bus_addr, data_o, data_i, wr_seen;
	logic [7:0]  strobe_len;
	int          n_fail = 0;
	int          samples_checked = 0;
	// Register clock and an unrelated bus clock
	initial forever #4 aclk = ~aclk;
	initial
	begin
		#13;
		forever #32 bus_clk = ~bus_clk;
	end
	ext_bus_ctrl i_ext_bus_ctrl (
		.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
		.s_rready, .bus_clk, .ready_in, .hold_req_n, .bus_release_grant_n,
		.bus_regain_request_n, .bus_addr, .ale_o, .ale_oe_n(), .rd_n_o,
		.wr_n_o, .strobe_oe_n, .data_o, .data_oe_n, .data_i
	);
	ext_bus_far i_ext_bus_far (
		.bus_clk, .rd_n_o, .wr_n_o, .strobe_oe_n, .bus_addr, .data_o,
		.data_oe_n, .pol,
		.dly, .want_bus, .ready_in, .hold_req_n, .data_i, .wr_seen, .strobe_len
	);
	task automatic results();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	// Seen value must exceed the bound
	task automatic chk_gt(input string nm, input logic [31:0] lo, g);
		samples_checked++;
		if ((g > lo) !== 1'b1)
		begin
			n_fail++;
			$display("unexpected %s: expected above %h, seen %h", nm, lo, g);
		end
	endtask : chk_gt
	task automatic tmo(input int n);
		if (n >= 200)
		begin
			n_fail++;
			$display("unexpected wait: expected done, seen timeout");
			results();
		end
	endtask : tmo
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		for (n = 0; n < 200; n++)
		begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid === 1'b1) break;
		end
		tmo(n);
		r = s_bresp;
		s_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		for (n = 0; n < 200; n++)
		begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid === 1'b1) break;
		end
		tmo(n);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 1'b0;
	endtask : rd
	task automatic wbusy(output logic [31:0] st);
		logic [1:0] r;
		int n;
		for (n = 0; n < 200; n++)
		begin
			rd(OFS_STATUS, st, r);
			if (st[STA_BUSY] === 1'b0) break;
		end
		tmo(n);
	endtask : wbusy
	task automatic wsig(ref logic s, input logic v);
		int n;
		for (n = 0; n < 200; n++)
		begin
			@(posedge bus_clk);
			if (s === v) break;
		end
		tmo(n);
		@(posedge aclk);
	endtask : wsig
	// One external cycle at 0x1234; returns status and read data
	task automatic cyc(input logic [31:0] ctrl, input logic w,
		output logic [31:0] st, d);
		logic [1:0] r;
		wr(OFS_CTRL, ctrl, r);
		wr(OFS_WDATA, 32'h0000_c3a5, r);
		wr(OFS_CMD, {16'h1234, 14'h0, w, 1'b1}, r);
		wbusy(st);
		rd(OFS_RDATA, d, r);
	endtask : cyc
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rd(OFS_CTRL, d, r);
		chk("ctrl reset", CTRL_RESET, d);
		rd(8'h20, d, r);
		chk("unmapped read", RESP_SLVERR, r);
		wr(8'h20, 32'h0000_00ff, r);
		chk("unmapped write", RESP_SLVERR, r);
		$display("test regs done");
	endtask : t_regs
	task automatic t_ready();
		logic [31:0] s1, s2, d;
		dly <= 4'h3;
		cyc(32'h0000_0005, 1'b0, s1, d);
		chk("read data", 32'h0000_edcb, d);
		dly <= 4'h6;
		cyc(32'h0000_0005, 1'b0, s2, d);
		chk_gt("longer ready waits", s1[15:8], s2[15:8]);
		dly <= 4'h3;
		cyc(32'h0000_0007, 1'b0, s2, d);
		chk_gt("async waits", s1[15:8], s2[15:8]);
		pol <= 1'b0;
		cyc(32'h0000_0004, 1'b0, s2, d);
		chk("low ready waits", s1[15:8], s2[15:8]);
		cyc(32'h0000_0004, 1'b1, s2, d);
		chk("write data", 32'h0000_c3a5, wr_seen);
		pol <= 1'b1;
		$display("test ready done");
	endtask : t_ready
	task automatic t_phase();
		logic [31:0] s, d;
		logic [7:0]  l0;
		dly <= 4'h0;
		cyc(32'h0000_0001, 1'b0, s, d);
		l0 = strobe_len;
		cyc(32'h0000_0601, 1'b0, s, d);
		chk("access length", l0 + 8'h06, strobe_len);
		cyc(32'h0000_0605, 1'b0, s, d);
		chk("waits after phase", 32'h0, s[15:8]);
		chk_gt("phase kept", 32'h6, strobe_len);
		$display("test phase done");
	endtask : t_phase
	task automatic t_arb();
		logic [31:0] s, d;
		logic [1:0]  r;
		dly <= 4'h8;
		wr(OFS_CTRL, 32'h0000_000d, r);
		wr(OFS_CMD, 32'h1234_0001, r);
		wsig(rd_n_o, 1'b0);
		want_bus <= 1'b1;
		wsig(bus_release_grant_n, 1'b0);
		rd(OFS_STATUS, s, r);
		chk("busy at grant", 32'h0, s[STA_BUSY]);
		chk("released flag", 32'h1, s[STA_REL]);
		rd(OFS_RDATA, d, r);
		chk("read before release", 32'h0000_edcb, d);
		wr(OFS_CMD, 32'h4321_0001, r);
		repeat (8) @(posedge bus_clk);
		@(posedge aclk);
		chk("regain request", 32'h0, bus_regain_request_n);
		chk("grant kept", 32'h0, bus_release_grant_n);
		want_bus <= 1'b0;
		wsig(bus_release_grant_n, 1'b1);
		wbusy(s);
		rd(OFS_RDATA, d, r);
		chk("read after regain", 32'h0000_bcde, d);
		want_bus <= 1'b1;
		wsig(bus_release_grant_n, 1'b0);
		chk("no own request", 32'h1, bus_regain_request_n);
		want_bus <= 1'b0;
		wsig(bus_release_grant_n, 1'b1);
		$display("test arbitration done");
	endtask : t_arb
	// Bus side needs four bus clocks of reset
	initial
	begin
		repeat (4) @(posedge bus_clk);
		@(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_ready();
		t_phase();
		t_arb();
		results();
	end
endmodule : tb_ext_bus_ready_and_arbitration
